/* File: tb/flash_dev_model.sv */
// Behavioural byte-wide flash: command decode, sector protection, query table.
// Assumes the host holds pins steady around each strobe edge; no clock.
`timescale 1ns/10ps
module flash_dev_model
    import flash_host_pkg::*;
(
    // Pins from the host
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic [20:0] addr_i,
    input  wire logic [7:0]  dq_i,
    input  wire logic        clear_hv_i,
    // Supply and protection flags, set by the bench
    input  wire logic        supply_ok_i,
    input  wire logic [31:0] prot_mask_i,
    // Read data to the host
    output logic [7:0]       dq_o
);
    // ************************************************************
    // Query table and state
    // ************************************************************
    // query table
    logic [7:0] qt [8'h10:8'h4C] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h27, 8'h36, 8'h00, 8'h00, 8'h04, 8'h00, 8'h0A, 8'h00, 8'h05,
        8'h00, 8'h04, 8'h00, 8'h15, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h40,
        8'h00, 8'h01, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h1E, 8'h00, 8'h00,
        8'h01, 8'h00, 8'h00, 8'h00, 8'h50, 8'h52, 8'h49, 8'h31, 8'h30, 8'h00, 8'h02, 8'h01,
        8'h01, 8'h04, 8'h00, 8'h00, 8'h00};
    // array mode, erased, unprotected at start
    logic [7:0] mem [int];
    logic [2:0] step = 3'h0;
    logic       in_as = 1'b0;
    logic       in_q = 1'b0;
    logic       q_ret = 1'b0;
    logic [7:0] val = 8'h00;
    logic [7:0] last = 8'h00;
    int         viol = 0;
    // read value; sector is addr[20:16], boot sectors folded in
    function automatic logic [7:0] rd(input logic [20:0] a);
        if (in_q)
            return (a[7:0] >= 8'h10 && a[7:0] <= 8'h4C) ? qt[a[7:0]] : 8'h00;
        if (in_as)
            return (a[1:0] == 2'h2) ? {7'h00, prot_mask_i[a[20:16]]} : 8'h00;
        return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
    endfunction
    // Recomputed at each gate fall so writes since the last read are seen
    always @(addr_i, in_q, in_as, oe_n_i)
        val = rd(addr_i);
    always @(posedge oe_n_i)
        last <= val;
    // Released bus shows the inverse of the last byte, never a stale copy
    assign dq_o = (!ce_n_i && !oe_n_i) ? val : ~last;
    task automatic take(input logic [20:0] a, input logic [7:0] d);
        logic ok;
        ok = !prot_mask_i[a[20:16]] || clear_hv_i;
        if (d == CMD_RESET)
        begin
            in_as = in_q && q_ret;
            in_q = 1'b0;
            step = 3'h0;
        end
        else if (d == CMD_QUERY && a[7:0] == QUERY_ADDR[7:0] && step == 3'h0 && !in_q)
        begin
            q_ret = in_as;
            in_q = 1'b1;
        end
        else if (step == 3'h0 || step == 3'h4)
            step = (a == UNLOCK_ADDR1 && d == UNLOCK_DATA1) ? step + 3'h1 : 3'h0;
        else if (step == 3'h1 || step == 3'h5)
            step = (a == UNLOCK_ADDR2 && d == UNLOCK_DATA2) ? step + 3'h1 : 3'h0;
        else if (step == 3'h2)
        begin
            in_as = (d == CMD_AUTOSEL);
            step = (d == CMD_PROGRAM) ? 3'h3 : (d == CMD_ERASE) ? 3'h4 : 3'h0;
        end
        else
        begin
            if (ok && step == 3'h3)
                mem[int'(a)] = rd(a) & d;
            if (ok && step == 3'h6 && d == CMD_SECTOR)
                foreach (mem[k])
                    if (k[20:16] == a[20:16])
                        mem[k] = 8'hFF;
            step = 3'h0;
        end
    endtask
    // strobe already low as supply rises: that edge is ignored
    logic pu_hold = 1'b0;
    always @(posedge supply_ok_i)
        pu_hold = (we_n_i === 1'b0) && (ce_n_i === 1'b0) && (oe_n_i === 1'b1);
    // write taken on strobe rise, only with select low and gate high
    always @(posedge we_n_i)
    begin
        if (!ce_n_i && oe_n_i && supply_ok_i && !pu_hold)
            take(addr_i, dq_i);
        pu_hold = 1'b0;
    end
    always @(negedge we_n_i)
        if (!oe_n_i)
            viol++;
    // low supply resets the command logic
    always @(negedge supply_ok_i)
    begin
        step = 3'h0;
        in_as = 1'b0;
        in_q = 1'b0;
    end
endmodule

/* File: tb/flash_protect_and_query_bench.sv */
// Self-checking bench for the flash host controller against a device model.
// Assumes the package constants; inputs change on the falling clock edge.
`timescale 1ns/10ps
module flash_protect_and_query_bench;
    import flash_host_pkg::*;
    // ************************************************************
    // Signals, clock, instances
    // ************************************************************
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        op_valid_i = 1'b0;
    logic [2:0]  op_code_i = 3'h0;
    logic [20:0] op_addr_i = 21'h000000;
    logic [7:0]  op_data_i = 8'h00;
    logic        temp_unprotect_i = 1'b0;
    logic        supply_ok_i = 1'b1;
    logic [31:0] prot_mask = 32'h00000000;
    logic        op_ready_o, op_done_o, in_query_o, in_autosel_o, ce_n_o, oe_n_o, we_n_o;
    logic        dq_oe_o, clear_hv_o;
    logic [7:0]  op_rdata_o, dq_i, dq_o, dev_dq, rdv;
    logic [20:0] addr_o;
    int          bad_count = 0;
    int          checks_done = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    // Wire level: host drives only while its enable is high
    assign dq_i = dq_oe_o ? dq_o : dev_dq;
    flash_protect_host uut (.clk_sys_i, .rst_n_i, .op_valid_i, .op_code_i, .op_addr_i,
        .op_data_i, .temp_unprotect_i, .supply_ok_i, .op_ready_o, .op_done_o, .op_rdata_o,
        .in_query_o, .in_autosel_o, .ce_n_o, .oe_n_o, .we_n_o, .addr_o, .dq_i, .dq_o,
        .dq_oe_o, .clear_hv_o);
    flash_dev_model dev (.ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .addr_i(addr_o),
        .dq_i(dq_o), .clear_hv_i(clear_hv_o), .supply_ok_i, .prot_mask_i(prot_mask),
        .dq_o(dev_dq));
    // Compare, verdict and bounded waits
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic stop_if(input int n);
        if (n >= 300)
        begin
            bad_count++;
            report_and_stop();
        end
    endtask
    // One operation; waits for ready, request held one cycle, result taken at done
    task automatic op(input logic [2:0] c, input logic [20:0] a, input logic [7:0] d);
        int n;
        for (n = 0; op_ready_o !== 1'b1 && n < 300; n++)
            @(negedge clk_sys_i);
        stop_if(n);
        op_code_i = c;
        op_addr_i = a;
        op_data_i = d;
        op_valid_i = 1'b1;
        @(negedge clk_sys_i);
        op_valid_i = 1'b0;
        for (n = 0; op_done_o !== 1'b1 && n < 300; n++)
            @(negedge clk_sys_i);
        stop_if(n);
        rdv = op_rdata_o;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_start;
        chk(in_query_o, 1'b0);
        chk(we_n_o, 1'b1);
        op(OP_READ, 21'h004000, 8'h00);
        chk(rdv, 8'hFF);
        op(OP_PROGRAM, 21'h004000, 8'h3C);
        op(OP_READ, 21'h004000, 8'h00);
        chk(rdv, 8'h3C);
        op(OP_WRITE, 21'h020000, 8'h00);
        op(OP_READ, 21'h020000, 8'h00);
        chk(rdv, 8'hFF);
        $display("test start done");
    endtask
    task automatic t_query;
        logic [15:0] spot [9] = '{16'h1051, 16'h1540, 16'h1F04, 16'h210A, 16'h2715,
            16'h2C04, 16'h391E, 16'h4331, 16'h4602};
        op(OP_QUERY, QUERY_ADDR, CMD_QUERY);
        chk(in_query_o, 1'b1);
        for (int i = 16; i <= 76; i++)
        begin
            op(OP_READ, 21'(i), 8'h00);
            chk(rdv, dev.qt[i]);
            foreach (spot[k])
                if (spot[k][15:8] == 8'(i))
                    chk(rdv, spot[k][7:0]);
        end
        op(OP_RESET, 21'h1ABCDE, CMD_RESET);
        chk(in_query_o, 1'b0);
        op(OP_READ, 21'h004000, 8'h00);
        chk(rdv, 8'h3C);
        $display("test query done");
    endtask
    task automatic t_autosel;
        prot_mask = 32'h00000002;
        op(OP_AUTOSEL, UNLOCK_ADDR1, CMD_AUTOSEL);
        chk(in_autosel_o, 1'b1);
        op(OP_QUERY, QUERY_ADDR, CMD_QUERY);
        op(OP_READ, 21'h000011, 8'h00);
        chk(rdv, 8'h52);
        op(OP_RESET, 21'h000000, CMD_RESET);
        chk(in_autosel_o, 1'b1);
        op(OP_READ, 21'h010002, 8'h00);
        chk(rdv, 8'h01);
        op(OP_RESET, 21'h000000, CMD_RESET);
        chk(in_autosel_o, 1'b0);
        $display("test autoselect done");
    endtask
    task automatic t_protect;
        op(OP_PROGRAM, 21'h010010, 8'h00);
        op(OP_READ, 21'h010010, 8'h00);
        chk(rdv, 8'hFF);
        temp_unprotect_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        chk(clear_hv_o, 1'b1);
        op(OP_PROGRAM, 21'h010010, 8'h5A);
        op(OP_READ, 21'h010010, 8'h00);
        chk(rdv, 8'h5A);
        temp_unprotect_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        op(OP_ERASE, 21'h010000, CMD_SECTOR);
        op(OP_READ, 21'h010010, 8'h00);
        chk(rdv, 8'h5A);
        prot_mask = 32'h00000000;
        op(OP_ERASE, 21'h010000, CMD_SECTOR);
        op(OP_READ, 21'h010010, 8'h00);
        chk(rdv, 8'hFF);
        chk(8'(dev.viol), 8'h00);
        $display("test protect done");
    endtask
    task automatic t_lockout;
        int n;
        op(OP_QUERY, QUERY_ADDR, CMD_QUERY);
        supply_ok_i = 1'b0;
        for (n = 0; op_ready_o !== 1'b0 && n < 10; n++)
            @(negedge clk_sys_i);
        chk(op_ready_o, 1'b0);
        // Mode falls back one edge after the synchronised supply drops
        @(negedge clk_sys_i);
        chk(in_query_o, 1'b0);
        supply_ok_i = 1'b1;
        op(OP_READ, 21'h004000, 8'h00);
        chk(rdv, 8'h3C);
        $display("test lockout done");
    endtask
    // Main sequence: reset for four cycles, then each scenario
    initial
    begin
        repeat (4) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        t_start();
        t_query();
        t_autosel();
        t_protect();
        t_lockout();
        report_and_stop();
    end
endmodule

/* File: verilog/flash_bus_cycle.sv */
// One asynchronous flash bus cycle: read or write, pin timing by counters.
// Assumes data input already synchronised by the caller.
`timescale 1ns/10ps
module flash_bus_cycle
    import flash_host_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    // Request side
    flash_cycle_if.eng        cyc,
    // Flash data input, synchronised
    input  wire logic [7:0]   dq_sync_i,
    // Flash pins
    output logic              ce_n_o,
    output logic              oe_n_o,
    output logic              we_n_o,
    output logic [20:0]       addr_o,
    output logic [7:0]        dq_out_o,
    output logic              dq_oe_o
);
    import flash_host_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD} cyc_state_e;
    typedef struct packed {
        cyc_state_e  st;
        logic [3:0]  cnt;
        logic        wr;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [20:0] addr;
        logic [7:0]  dout;
        logic        doe;
        logic        done;
        logic [7:0]  rdata;
    } cyc_s;
    cyc_s cur_ff, nxt_cur;

    // ************************************************************
    // Cycle sequencing
    // ************************************************************
    // Next state; address set before strobe so the latch edge is clean
    always_comb
    begin
        nxt_cur      = cur_ff;
        nxt_cur.done = 1'b0;
        case (cur_ff.st)
            S_IDLE:
            begin
                if (cyc.req)
                begin
                    nxt_cur.st   = S_SETUP;
                    nxt_cur.wr   = cyc.wr;
                    nxt_cur.addr = cyc.addr;
                    nxt_cur.dout = cyc.wdata;
                    nxt_cur.doe  = cyc.wr;
                    nxt_cur.ce_n = 1'b0;
                end
            end
            S_SETUP:
            begin
                nxt_cur.st   = S_PULSE;
                nxt_cur.oe_n = cur_ff.wr;
                nxt_cur.we_n = ~cur_ff.wr;
                nxt_cur.cnt  = cur_ff.wr ? PULSE_CNT : ACCESS_CNT + 4'h2;
            end
            S_PULSE:
            begin
                if (cur_ff.cnt != 4'h0)
                    nxt_cur.cnt = cur_ff.cnt - 4'h1;
                else
                begin
                    // Data latched on rising write strobe
                    nxt_cur.st    = S_HOLD;
                    nxt_cur.we_n  = 1'b1;
                    nxt_cur.oe_n  = 1'b1;
                    nxt_cur.rdata = dq_sync_i;
                end
            end
            S_HOLD:
            begin
                nxt_cur.st   = S_IDLE;
                nxt_cur.ce_n = 1'b1;
                nxt_cur.doe  = 1'b0;
                nxt_cur.done = 1'b1;
            end
            default:
                nxt_cur.st = S_IDLE;
        endcase
    end

    // State register, all strobes idle high
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cur_ff <= '{st: S_IDLE, cnt: 4'h0, wr: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
                        we_n: 1'b1, addr: 21'h000000, dout: 8'h00, doe: 1'b0,
                        done: 1'b0, rdata: 8'h00};
        else
            cur_ff <= nxt_cur;
    end

    assign ce_n_o    = cur_ff.ce_n;
    assign oe_n_o    = cur_ff.oe_n;
    assign we_n_o    = cur_ff.we_n;
    assign addr_o    = cur_ff.addr;
    assign dq_out_o  = cur_ff.dout;
    assign dq_oe_o   = cur_ff.doe;
    assign cyc.done  = cur_ff.done;
    assign cyc.rdata = cur_ff.rdata;

    // ************************************************************
    // Checks
    // ************************************************************
    // no write with gate low
    property p_no_write_gate;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !we_n_o |-> (oe_n_o && !ce_n_o);
    endproperty
    a_no_write_gate: assert property (p_no_write_gate)
        else $error("write strobe low while output gate low or chip deselected");

    property p_pulse_len;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $fell(we_n_o) |-> !we_n_o [*2] ##1 we_n_o;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("write pulse length wrong");
endmodule

/* File: verilog/flash_cycle_if.sv */
// Carrier between the sequencer and the single bus cycle engine.
// Assumes both ends share clk_sys_i.
`timescale 1ns/10ps
interface flash_cycle_if;
    logic        req;
    logic        wr;
    logic [20:0] addr;
    logic [7:0]  wdata;
    logic        done;
    logic [7:0]  rdata;
    modport seq (output req, wr, addr, wdata, input done, rdata);
    modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

/* File: verilog/flash_host_pkg.sv */
// Constants for the flash host controller: commands, addresses, timing.
// Assumes a 25 MHz system clock and a byte-wide asynchronous flash outside.
package flash_host_pkg;
    // ************************************************************
    // Widths
    // ************************************************************
    localparam int ADDR_W = 21;
    localparam int DATA_W = 8;
    // ************************************************************
    // Command addresses and data
    // ************************************************************
    localparam logic [20:0] UNLOCK_ADDR1 = 21'h000555;
    localparam logic [20:0] UNLOCK_ADDR2 = 21'h0002AA;
    localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
    localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
    localparam logic [7:0]  CMD_ERASE    = 8'h80;
    localparam logic [7:0]  CMD_SECTOR   = 8'h30;
    localparam logic [7:0]  CMD_AUTOSEL  = 8'h90;
    localparam logic [7:0]  CMD_RESET    = 8'hF0;
    localparam logic [20:0] QUERY_ADDR   = 21'h000055;
    localparam logic [7:0]  CMD_QUERY    = 8'h98;
    // ************************************************************
    // Host operation codes
    // ************************************************************
    localparam logic [2:0] OP_READ    = 3'h0;
    localparam logic [2:0] OP_RESET   = 3'h1;
    localparam logic [2:0] OP_QUERY   = 3'h2;
    localparam logic [2:0] OP_PROGRAM = 3'h3;
    localparam logic [2:0] OP_ERASE   = 3'h4;
    localparam logic [2:0] OP_AUTOSEL = 3'h5;
    localparam logic [2:0] OP_WRITE   = 3'h6;
    // ************************************************************
    // Bus timing
    // ************************************************************
    localparam int CLK_MHZ       = 25;
    localparam int ACCESS_NS     = 70;
    localparam int PULSE_NS      = 35;
    localparam int ACCESS_CYC    = (ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_CYC     = (PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] ACCESS_CNT = 4'(ACCESS_CYC);
    localparam logic [3:0] PULSE_CNT  = 4'(PULSE_CYC);
endpackage

/* File: verilog/flash_protect_host.sv */
// Host controller for a byte-wide boot-sector flash: commands, query, protect.
// Assumes an external level shifter drives the reset pin to high voltage.
`timescale 1ns/10ps
module flash_protect_host
    import flash_host_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    // User command port
    input  wire logic                 op_valid_i,
    input  wire logic [2:0]           op_code_i,
    input  wire logic [ADDR_W-1:0]    op_addr_i,
    input  wire logic [DATA_W-1:0]    op_data_i,
    input  wire logic                 temp_unprotect_i,
    input  wire logic                 supply_ok_i,
    output logic                      op_ready_o,
    output logic                      op_done_o,
    output logic [DATA_W-1:0]         op_rdata_o,
    output logic                      in_query_o,
    output logic                      in_autosel_o,
    // Flash pins
    output logic                      ce_n_o,
    output logic                      oe_n_o,
    output logic                      we_n_o,
    output logic [ADDR_W-1:0]         addr_o,
    input  wire logic [DATA_W-1:0]    dq_i,
    output logic [DATA_W-1:0]         dq_o,
    output logic                      dq_oe_o,
    output logic                      clear_hv_o
);
    import flash_host_pkg::*;

    typedef enum logic [1:0] {M_ARRAY, M_AUTOSEL, M_QUERY} dev_mode_e;
    typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} host_state_e;
    typedef struct packed {
        host_state_e st;
        logic [2:0]  step;
        logic [2:0]  nsteps;
        logic [2:0]  op;
        dev_mode_e   mode;
        dev_mode_e   query_ret;
        logic [20:0] addr;
        logic [7:0]  data;
        logic        req;
        logic        done;
        logic [7:0]  rdata;
        logic        hv;
        logic        sup_seen;
        logic        inq;
        logic        inas;
    } host_s;
    host_s cur_ff, nxt_cur;

    logic [7:0] dq_meta_ff;
    logic [7:0] dq_sync_ff;
    logic       sup_meta_ff;
    logic       sup_sync_ff;
    logic [20:0] seq_addr;
    logic [7:0]  seq_data;
    logic        eng_ce_n;
    logic        eng_oe_n;
    logic        eng_we_n;
    logic [20:0] eng_addr;
    logic [7:0]  eng_dq;
    logic        eng_doe;

    flash_cycle_if cyc ();

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Pins are asynchronous to the system clock
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dq_meta_ff  <= 8'h00;
            dq_sync_ff  <= 8'h00;
            sup_meta_ff <= 1'b0;
            sup_sync_ff <= 1'b0;
        end
        else
        begin
            dq_meta_ff  <= dq_i;
            dq_sync_ff  <= dq_meta_ff;
            sup_meta_ff <= supply_ok_i;
            sup_sync_ff <= sup_meta_ff;
        end
    end

    // ************************************************************
    // Command sequence tables
    // ************************************************************
    // Address of each step; unlock pair comes first for program, erase and autoselect only
    function automatic logic [20:0] step_addr(input logic [2:0] op,
                                              input logic [2:0] step,
                                              input logic [20:0] uaddr);
        logic [20:0] a;
        a = UNLOCK_ADDR1;
        case (step)
            3'h0: a = (op == OP_QUERY) ? QUERY_ADDR : UNLOCK_ADDR1;
            3'h1: a = UNLOCK_ADDR2;
            3'h2: a = UNLOCK_ADDR1;
            3'h3: a = (op == OP_ERASE) ? UNLOCK_ADDR1 : uaddr;
            3'h4: a = UNLOCK_ADDR2;
            default: a = uaddr;
        endcase
        if (op == OP_RESET || op == OP_READ || op == OP_WRITE)
            a = uaddr;
        return a;
    endfunction

    // Data of each step
    function automatic logic [7:0] step_data(input logic [2:0] op,
                                             input logic [2:0] step,
                                             input logic [7:0] udata);
        logic [7:0] d;
        d = udata;
        case (op)
            OP_RESET: d = CMD_RESET;
            OP_QUERY: d = CMD_QUERY;
            OP_PROGRAM, OP_ERASE, OP_AUTOSEL:
            begin
                case (step)
                    3'h0, 3'h3: d = (op == OP_ERASE) ? UNLOCK_DATA1 : udata;
                    3'h1, 3'h4: d = UNLOCK_DATA2;
                    3'h2: d = (op == OP_PROGRAM) ? CMD_PROGRAM :
                              (op == OP_ERASE) ? CMD_ERASE : CMD_AUTOSEL;
                    default: d = CMD_SECTOR;
                endcase
                if (step == 3'h0)
                    d = UNLOCK_DATA1;
            end
            default: d = udata;
        endcase
        return d;
    endfunction

    assign seq_addr = step_addr(cur_ff.op, cur_ff.step, cur_ff.addr);
    assign seq_data = step_data(cur_ff.op, cur_ff.step, cur_ff.data);

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Steps through the cycles of one operation; tracks device mode
    always_comb
    begin
        nxt_cur          = cur_ff;
        nxt_cur.done     = 1'b0;
        nxt_cur.req      = 1'b0;
        nxt_cur.sup_seen = cur_ff.sup_seen | sup_sync_ff;
        nxt_cur.hv       = temp_unprotect_i;
        case (cur_ff.st)
            H_IDLE:
            begin
                if (op_valid_i && sup_sync_ff)
                begin
                    nxt_cur.st     = H_ISSUE;
                    nxt_cur.op     = op_code_i;
                    nxt_cur.addr   = op_addr_i;
                    nxt_cur.data   = op_data_i;
                    nxt_cur.step   = 3'h0;
                    case (op_code_i)
                        OP_PROGRAM: nxt_cur.nsteps = 3'h3;
                        OP_AUTOSEL: nxt_cur.nsteps = 3'h2;
                        OP_ERASE:   nxt_cur.nsteps = 3'h5;
                        default:    nxt_cur.nsteps = 3'h0;
                    endcase
                end
            end
            H_ISSUE:
            begin
                nxt_cur.st  = H_WAIT;
                nxt_cur.req = 1'b1;
            end
            H_WAIT:
            begin
                if (cyc.done)
                begin
                    if (cur_ff.step != cur_ff.nsteps)
                    begin
                        nxt_cur.step = cur_ff.step + 3'h1;
                        nxt_cur.st   = H_ISSUE;
                    end
                    else
                    begin
                        nxt_cur.st    = H_IDLE;
                        nxt_cur.done  = 1'b1;
                        nxt_cur.rdata = cyc.rdata;
                        case (cur_ff.op)
                            OP_QUERY:
                            begin
                                if (cur_ff.mode != M_QUERY)
                                    nxt_cur.query_ret = cur_ff.mode;
                                nxt_cur.mode = M_QUERY;
                            end
                            OP_RESET:
                                nxt_cur.mode = (cur_ff.mode == M_QUERY) ?
                                               cur_ff.query_ret : M_ARRAY;
                            OP_AUTOSEL: nxt_cur.mode = M_AUTOSEL;
                            default: nxt_cur.mode = cur_ff.mode;
                        endcase
                    end
                end
            end
            default:
                nxt_cur.st = H_IDLE;
        endcase
        if (!sup_sync_ff && cur_ff.sup_seen)
            nxt_cur.mode = M_ARRAY;
        // Mode flags registered so the outputs leave flip-flops
        nxt_cur.inq  = (nxt_cur.mode == M_QUERY);
        nxt_cur.inas = (nxt_cur.mode == M_AUTOSEL);
    end

    // device assumed in array read at start
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cur_ff <= '{st: H_IDLE, step: 3'h0, nsteps: 3'h0, op: OP_READ,
                        mode: M_ARRAY, query_ret: M_ARRAY, addr: 21'h000000,
                        data: 8'h00, req: 1'b0, done: 1'b0, rdata: 8'h00,
                        hv: 1'b0, sup_seen: 1'b0, inq: 1'b0, inas: 1'b0};
        else
            cur_ff <= nxt_cur;
    end

    // Read and plain write are single cycles
    assign cyc.req   = cur_ff.req;
    assign cyc.wr    = (cur_ff.op != OP_READ);
    assign cyc.addr  = seq_addr;
    assign cyc.wdata = seq_data;

    // query reads go through normal read cycle
    flash_bus_cycle u_cycle (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .cyc       (cyc.eng),
        .dq_sync_i (dq_sync_ff),
        .ce_n_o    (eng_ce_n),
        .oe_n_o    (eng_oe_n),
        .we_n_o    (eng_we_n),
        .addr_o    (eng_addr),
        .dq_out_o  (eng_dq),
        .dq_oe_o   (eng_doe)
    );

    // Bus pins straight from engine flip-flops; clear_hv_o from the sequencer register
    assign ce_n_o       = eng_ce_n;
    assign oe_n_o       = eng_oe_n;
    assign we_n_o       = eng_we_n;
    assign addr_o       = eng_addr;
    assign dq_o         = eng_dq;
    assign dq_oe_o      = eng_doe;
    assign clear_hv_o   = cur_ff.hv;
    assign op_ready_o   = (cur_ff.st == H_IDLE) && sup_sync_ff;
    assign op_done_o    = cur_ff.done;
    assign op_rdata_o   = cur_ff.rdata;
    assign in_query_o   = cur_ff.inq;
    assign in_autosel_o = cur_ff.inas;

    // ************************************************************
    // Checks
    // ************************************************************
    // reset from query restores origin
    property p_query_exit;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (cyc.done && cur_ff.st == H_WAIT && cur_ff.op == OP_RESET
         && cur_ff.mode == M_QUERY && sup_sync_ff)
        |=> (cur_ff.mode == $past(cur_ff.query_ret));
    endproperty
    a_query_exit: assert property (p_query_exit)
        else $error("reset did not return to mode before query");

    property p_query_addr;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (cyc.req && cur_ff.op == OP_QUERY) |-> (cyc.addr == QUERY_ADDR
                                              && cyc.wdata == CMD_QUERY);
    endproperty
    a_query_addr: assert property (p_query_addr)
        else $error("query command on wrong address or data");

    property p_unlock_first;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (cyc.req && cur_ff.op == OP_PROGRAM && cur_ff.step == 3'h0)
        |-> (cyc.addr == UNLOCK_ADDR1 && cyc.wdata == UNLOCK_DATA1);
    endproperty
    a_unlock_first: assert property (p_unlock_first)
        else $error("program did not start with unlock cycle");

    property p_supply_gate;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (!sup_sync_ff && cur_ff.st == H_IDLE) |=> (cur_ff.st == H_IDLE);
    endproperty
    a_supply_gate: assert property (p_supply_gate)
        else $error("operation started below supply lockout");
endmodule
